// ===== design/mcd_consts.vh
// constants for the motion command decoder
`ifndef MCD_CONSTS_VH
`define MCD_CONSTS_VH
`define MCD_CMD_SPIN_RIGHT   8'h01
`define MCD_CMD_SPIN_LEFT    8'h02
`define MCD_CMD_HALT         8'h03
`define MCD_CMD_MOVE         8'h04
`define MCD_CMD_WRITE_PARAM  8'h05
`define MCD_CMD_READ_PARAM   8'h06
`define MCD_TYPE_ABSOLUTE    8'h00
`define MCD_TYPE_RELATIVE    8'h01
`define MCD_TYPE_STORED      8'h02
`define MCD_PARAM_TARGET_POS 8'h00
`define MCD_PARAM_ACTUAL_POS 8'h01
`define MCD_PARAM_TARGET_VEL 8'h02
`define MCD_NUM_PARAMS       16
`define MCD_NUM_POINTS       21
`define MCD_STATUS_OK        8'h64
`define MCD_STATUS_BAD_SUM   8'h01
`define MCD_STATUS_BAD_CMD   8'h02
`define MCD_STATUS_BAD_TYPE  8'h03
`define MCD_STATUS_BAD_VALUE 8'h04
`define MCD_FRAME_LEN        4'h9
`endif

// ===== design/mcd_motion_command_decoder.v
// command frame decoder for one stepper axis
//
// Overview of operation
// R01 - stop command is code 03h with type, bank and value all zero
// R02 - stop selects velocity mode with zero target speed for soft stop
// R03 - move replies at once and further commands are accepted during travel
// R04 - move uses ramp and maximum speed held in axis parameters
// R05 - move position value is a 32-bit signed integer
// R06 - code 4 is move; type 0 absolute, 1 relative, 2 stored point
// R07 - relative target is actual position plus signed offset; host keeps range
// R08 - shorter path taken through 32-bit wraparound
// R09 - host defines a stored point before moving to it
// R10 - every move writes its result into axis parameter 0
// R11 - stop or spin command aborts a positioning move in progress
// R12 - stop, move and parameter write answer status 100 in direct mode
// R13 - code 5 bank 0 writes value into axis parameter chosen by type
// R14 - axis parameters live in volatile storage only
// R15 - read from stored program also copies value into accumulator
// R16 - direct read returns value in reply only, accumulator unchanged
// R17 - frame order: address, code, type, bank, value msb first, checksum
// R18 - checksum is sum modulo 256 of the eight bytes before it
// R19 - move with type other than 0, 1 or 2 gets error, target kept
`timescale 1ns/1ps
`default_nettype none
`include "mcd_consts.vh"
module mcd_motion_command_decoder (
	input  wire        clock,
	input  wire        rstn,
	input  wire        frame_valid,
	input  wire [7:0]  frame_byte,
	input  wire        from_program,
	input  wire [31:0] actual_position,
	input  wire        point_write,
	input  wire [4:0]  point_index,
	input  wire [31:0] point_value,
	output reg         reply_valid,
	output reg  [7:0]  reply_address,
	output reg  [7:0]  reply_status,
	output reg  [7:0]  reply_code,
	output reg  [31:0] reply_value,
	output reg  [31:0] accumulator,
	output reg         velocity_mode,
	output reg  [31:0] target_position,
	output reg  [31:0] target_velocity,
	output reg  [31:0] max_position_speed,
	output reg  [31:0] ramp_accel,
	output reg  [31:0] ramp_decel,
	output reg         move_start,
	output reg         move_busy,
	output reg  [31:0] move_distance
);
	localparam ST_COLLECT = 3'b001;
	localparam ST_EXECUTE = 3'b010;
	localparam ST_REPLY   = 3'b100;

	reg  [2:0]  state;
	reg  [3:0]  byte_count;
	reg  [7:0]  frame_addr;
	reg  [7:0]  frame_code;
	reg  [7:0]  frame_type;
	reg  [7:0]  frame_bank;
	reg  [31:0] frame_value;
	reg  [7:0]  frame_sum;
	reg  [7:0]  frame_check;
	reg         latched_program;
	// volatile only: contents vanish with power and reset
	reg  [31:0] axis_param [0:`MCD_NUM_PARAMS-1]; // R14
	reg  [31:0] stored_point [0:`MCD_NUM_POINTS-1];
	reg  [31:0] next_target;
	reg  [31:0] read_value;
	wire [3:0]  param_sel;
	wire        sum_ok;
	wire        halt_ok;
	wire        last_byte;
	wire        exec_ok;
	wire        bank_zero;
	wire        param_write;
	wire        move_type_bad;
	wire        point_bad;
	wire        move_accept;
	wire        move_abort;
	wire        arrived;

	assign param_sel = frame_type[3:0];
	assign sum_ok = (frame_sum == frame_check); // R18
	assign halt_ok = (frame_type == 8'h00) && (frame_bank == 8'h00) &&
		(frame_value == 32'h0000_0000); // R01
	assign last_byte = (byte_count == `MCD_FRAME_LEN - 4'h1); // R17
	assign exec_ok = (state == ST_EXECUTE) && sum_ok;
	assign bank_zero = (frame_bank == 8'h00);
	assign param_write = exec_ok && bank_zero &&
		(frame_code == `MCD_CMD_WRITE_PARAM); // R13
	assign move_type_bad = (frame_type > `MCD_TYPE_STORED); // R19
	// only points 0..20 exist; larger numbers are refused
	assign point_bad = (frame_type == `MCD_TYPE_STORED) &&
		(frame_value >= `MCD_NUM_POINTS);
	assign move_accept = exec_ok && (frame_code == `MCD_CMD_MOVE) &&
		!move_type_bad && !point_bad; // R06
	// stop and both spins end a positioning move
	assign move_abort = exec_ok &&
		(((frame_code == `MCD_CMD_HALT) && halt_ok) ||
		(frame_code == `MCD_CMD_SPIN_RIGHT) ||
		(frame_code == `MCD_CMD_SPIN_LEFT)); // R11
	assign arrived = move_busy && (actual_position == target_position);

	// relative sum wraps modulo 2^32, host keeps it in range
	always @* begin
		case (frame_type)
		`MCD_TYPE_RELATIVE: next_target = actual_position + frame_value; // R07
		`MCD_TYPE_STORED:
			next_target = stored_point[frame_value[4:0]];
		default: next_target = frame_value; // R05
		endcase
	end

	always @* begin
		case (frame_type)
		`MCD_PARAM_TARGET_POS: read_value = target_position;
		`MCD_PARAM_ACTUAL_POS: read_value = actual_position;
		`MCD_PARAM_TARGET_VEL: read_value = target_velocity;
		default: read_value = axis_param[param_sel];
		endcase
	end

	genvar gi;
	generate
		// points are written only from point_value at point_index by point_write
		for (gi = 0; gi < `MCD_NUM_POINTS; gi = gi + 1) begin : g_point
			always @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					stored_point[gi] <= 32'h0000_0000;
				end else if (point_write && point_index == gi) begin // R09
					stored_point[gi] <= point_value;
				end
			end
		end
		for (gi = 0; gi < `MCD_NUM_PARAMS; gi = gi + 1) begin : g_param
			always @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					axis_param[gi] <= 32'h0000_0000;
				end else if (param_write && param_sel == gi) begin // R13
					axis_param[gi] <= frame_value;
				end
			end
		end
	endgenerate

	// ramp figures follow the parameter store every cycle
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			max_position_speed <= 32'h0000_0000;
			ramp_accel         <= 32'h0000_0000;
			ramp_decel         <= 32'h0000_0000;
		end else begin
			max_position_speed <= axis_param[4]; // R04
			ramp_accel         <= axis_param[5]; // R04
			ramp_decel         <= axis_param[6]; // R04
		end
	end

	// a new move wins over arrival in the same cycle
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			move_start    <= 1'b0;
			move_busy     <= 1'b0;
			move_distance <= 32'h0000_0000;
		end else begin
			move_start <= move_accept; // R03
			if (move_accept) begin
				move_busy     <= 1'b1; // R03
				// signed difference: wrap picks shorter way
				move_distance <= next_target - actual_position; // R08
			end else if (move_abort || arrived) begin
				move_busy <= 1'b0; // R11
			end
		end
	end

	// every move and a write of parameter 0 land in the target
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			target_position <= 32'h0000_0000;
		end else if (move_accept) begin
			target_position <= next_target; // R10
		end else if (param_write &&
			frame_type == `MCD_PARAM_TARGET_POS) begin
			target_position <= frame_value; // R13
		end
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state              <= ST_COLLECT;
			byte_count         <= 4'h0;
			frame_addr         <= 8'h00;
			frame_code         <= 8'h00;
			frame_type         <= 8'h00;
			frame_bank         <= 8'h00;
			frame_value        <= 32'h0000_0000;
			frame_sum          <= 8'h00;
			frame_check        <= 8'h00;
			latched_program    <= 1'b0;
			reply_valid        <= 1'b0;
			reply_address      <= 8'h00;
			reply_status       <= 8'h00;
			reply_code         <= 8'h00;
			reply_value        <= 32'h0000_0000;
			accumulator        <= 32'h0000_0000;
			velocity_mode      <= 1'b0;
			target_velocity    <= 32'h0000_0000;
		end else begin
			reply_valid <= 1'b0;
			case (state)
			ST_COLLECT: begin
				if (frame_valid) begin // R17
					byte_count <= byte_count + 4'h1;
					// first byte restarts the sum so frames never mix
					if (byte_count == 4'h0) begin
						frame_sum <= frame_byte; // R18
					end else if (!last_byte) begin
						frame_sum <= frame_sum + frame_byte; // R18
					end
					case (byte_count)
					4'h0: frame_addr <= frame_byte;
					4'h1: frame_code <= frame_byte;
					4'h2: frame_type <= frame_byte;
					4'h3: frame_bank <= frame_byte;
					4'h4: frame_value[31:24] <= frame_byte;
					4'h5: frame_value[23:16] <= frame_byte;
					4'h6: frame_value[15:8] <= frame_byte;
					4'h7: frame_value[7:0] <= frame_byte;
					default: begin
						frame_check     <= frame_byte;
						latched_program <= from_program;
						byte_count      <= 4'h0;
						state           <= ST_EXECUTE;
					end
					endcase
				end
			end
			ST_EXECUTE: begin
				reply_address <= frame_addr;
				reply_code    <= frame_code;
				reply_value   <= 32'h0000_0000;
				reply_status  <= `MCD_STATUS_OK; // R12
				if (!sum_ok) begin
					reply_status <= `MCD_STATUS_BAD_SUM; // R18
				end else begin
					case (frame_code)
					`MCD_CMD_HALT: begin
						if (halt_ok) begin
							velocity_mode   <= 1'b1; // R02
							target_velocity <= 32'h0000_0000; // R02
						end else begin
							reply_status <= `MCD_STATUS_BAD_VALUE;
						end
					end
					`MCD_CMD_SPIN_RIGHT, `MCD_CMD_SPIN_LEFT: begin
						velocity_mode   <= 1'b1;
						target_velocity <= (frame_code == `MCD_CMD_SPIN_LEFT) ?
							(32'h0000_0000 - frame_value) : frame_value;
					end
					`MCD_CMD_MOVE: begin // R06
						if (move_type_bad) begin
							reply_status <= `MCD_STATUS_BAD_TYPE; // R19
						end else if (point_bad) begin
							reply_status <= `MCD_STATUS_BAD_VALUE;
						end else begin
							velocity_mode <= 1'b0;
						end
					end
					`MCD_CMD_WRITE_PARAM: begin
						if (!bank_zero) begin
							reply_status <= `MCD_STATUS_BAD_VALUE;
						end else if (frame_type == `MCD_PARAM_TARGET_VEL) begin
							target_velocity <= frame_value; // R13
						end
					end
					`MCD_CMD_READ_PARAM: begin
						reply_value <= read_value; // R16
						if (latched_program) begin
							accumulator <= read_value; // R15
						end
					end
					default: reply_status <= `MCD_STATUS_BAD_CMD;
					endcase
				end
				state <= ST_REPLY;
			end
			ST_REPLY: begin
				reply_valid <= 1'b1; // R03
				state       <= ST_COLLECT;
			end
			default: state <= ST_COLLECT;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== tb/mcd_checker_assertions.sv
// assertions on the decoder ports
`timescale 1ns/1ps
`default_nettype none
module mcd_checker (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        frame_valid,
	input wire logic [31:0] actual_position,
	input wire logic        reply_valid,
	input wire logic [7:0]  reply_status,
	input wire logic [7:0]  reply_code,
	input wire logic [31:0] accumulator,
	input wire logic        velocity_mode,
	input wire logic [31:0] target_position,
	input wire logic [31:0] target_velocity,
	input wire logic [31:0] max_position_speed,
	input wire logic        move_start,
	input wire logic        move_busy,
	input wire logic [31:0] move_distance
);
	logic [3:0] nb;
	// byte position in frame; bench never sends in the refused gap
	always_ff @(posedge clock or negedge rstn)
		if (!rstn)
			nb <= 4'h0;
		else if (frame_valid)
			nb <= (nb == 4'h8) ? 4'h0 : nb + 4'h1;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	property p_frame; frame_valid && nb == 4'h8 |-> ##3 reply_valid; endproperty
	a_frame: assert property (p_frame) else $error("no reply");
	property p_move; move_start |-> ##1 reply_valid && reply_status == 8'h64
		&& reply_code == 8'h04; endproperty
	a_move: assert property (p_move) else $error("move reply");
	property p_mode; move_start |-> !velocity_mode && move_busy; endproperty
	a_mode: assert property (p_mode) else $error("move mode");
	property p_halt; reply_valid && reply_code == 8'h03 && reply_status ==
		8'h64 |-> velocity_mode && target_velocity == 0 && !move_busy;
	endproperty
	a_halt: assert property (p_halt) else $error("halt state");
	property p_acc; $changed(accumulator) |-> ##1 reply_valid &&
		reply_code == 8'h06; endproperty
	a_acc: assert property (p_acc) else $error("accumulator");
	property p_par; $changed(max_position_speed) |-> reply_valid &&
		reply_code == 8'h05; endproperty
	a_par: assert property (p_par) else $error("param write");
	property p_rej; reply_valid && reply_status != 8'h64 |->
		target_position == $past(target_position, 2); endproperty
	a_rej: assert property (p_rej) else $error("reject moved");
	property p_dist; move_start |->
		move_distance == target_position - $past(actual_position); endproperty
	a_dist: assert property (p_dist) else $error("distance");
endmodule
`default_nettype wire

// ===== tb/mcd_host_model.sv
// host that sends command frames
`timescale 1ns/1ps
`default_nettype none
module mcd_host_model (
	input  wire logic       clock,
	output var  logic       frame_valid,
	output var  logic [7:0] frame_byte,
	output var  logic       from_program
);
	initial begin
		frame_valid = 1'b0;
		frame_byte = 8'h00;
		from_program = 1'b0;
	end
	task automatic send(input logic [63:0] f, input logic p, input logic bad);
		logic [7:0] s;
		s = {7'h00, bad};
		@(posedge clock);
		from_program <= p;
		for (int i = 7; i >= 0; i--) begin
			s = s + f[i*8 +: 8];
			frame_byte <= f[i*8 +: 8];
			frame_valid <= 1'b1;
			@(posedge clock);
		end
		frame_byte <= s;
		@(posedge clock);
		frame_valid <= 1'b0;
		// released line: show inverse so stale data cannot pass
		frame_byte <= ~s;
	endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// testbench for the motion command decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
	$display("Error at %0t: got %h want %h", $time, a, b); end end
module tb;
	logic clock = 1'b0, rstn = 1'b0, point_write = 1'b0;
	logic frame_valid, from_program;
	logic [7:0] frame_byte;
	logic [4:0] point_index = 5'h00;
	logic [31:0] actual_position = 32'h0000_03e8, point_value = 32'h0000_0000;
	logic reply_valid, velocity_mode, move_start, move_busy;
	logic [7:0] reply_address, reply_status, reply_code;
	logic [31:0] reply_value, accumulator, target_position, target_velocity;
	logic [31:0] max_position_speed, ramp_accel, ramp_decel, move_distance;
	int checks = 0, fail_count = 0;
	mcd_motion_command_decoder dut_u (
		.clock              (clock),
		.rstn               (rstn),
		.frame_valid        (frame_valid),
		.frame_byte         (frame_byte),
		.from_program       (from_program),
		.actual_position    (actual_position),
		.point_write        (point_write),
		.point_index        (point_index),
		.point_value        (point_value),
		.reply_valid        (reply_valid),
		.reply_address      (reply_address),
		.reply_status       (reply_status),
		.reply_code         (reply_code),
		.reply_value        (reply_value),
		.accumulator        (accumulator),
		.velocity_mode      (velocity_mode),
		.target_position    (target_position),
		.target_velocity    (target_velocity),
		.max_position_speed (max_position_speed),
		.ramp_accel         (ramp_accel),
		.ramp_decel         (ramp_decel),
		.move_start         (move_start),
		.move_busy          (move_busy),
		.move_distance      (move_distance)
	);
	mcd_host_model host_u (
		.clock        (clock),
		.frame_valid  (frame_valid),
		.frame_byte   (frame_byte),
		.from_program (from_program)
	);
	initial forever #5 clock = ~clock;
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] c, t, input logic [31:0] v,
		input logic p = 0, input logic bad = 0);
		host_u.send({8'h01, c, t, 8'h00, v}, p, bad);
		for (int i = 0; i < 4 && !reply_valid; i++) begin
			@(posedge clock);
			#1;
		end
		if (reply_valid !== 1'b1) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	task automatic t_param;
		cmd(8'h05, 8'h04, 32'h0000_c800);
		`CHK({reply_status, reply_address}, {8'h64, 8'h01})
		cmd(8'h05, 8'h05, 32'h0000_1234);
		cmd(8'h05, 8'h06, 32'h0000_5678);
		`CHK({max_position_speed, ramp_accel, ramp_decel},
			{32'h0000_c800, 32'h0000_1234, 32'h0000_5678})
	endtask
	task automatic t_moves;
		cmd(8'h04, 8'h00, 32'h8000_0000);
		`CHK(target_position, 32'h8000_0000)
		cmd(8'h04, 8'h01, 32'hffff_d8f0);
		`CHK({reply_status, move_busy}, {8'h64, 1'b1})
		`CHK(target_position, 32'hffff_dcd8)
		@(posedge clock);
		actual_position <= 32'hffff_fffe;
		cmd(8'h04, 8'h00, 32'h7fff_ffff);
		repeat (2) @(posedge clock);
		#1 `CHK(move_distance, 32'h8000_0001)
	endtask
	task automatic t_point;
		@(posedge clock);
		point_index <= 5'd8;
		point_value <= 32'h0001_5f90;
		point_write <= 1'b1;
		@(posedge clock);
		point_write <= 1'b0;
		cmd(8'h04, 8'h02, 32'h0000_0008);
		`CHK(target_position, 32'h0001_5f90)
		cmd(8'h04, 8'h03, 32'h0000_0005);
		`CHK({reply_status, target_position}, {8'h03, 32'h0001_5f90})
		cmd(8'h04, 8'h00, 32'h0000_0007, 1'b0, 1'b1);
		`CHK({reply_status, target_position}, {8'h01, 32'h0001_5f90})
	endtask
	task automatic t_halt_read;
		cmd(8'h05, 8'h02, 32'h0000_c800);
		`CHK({velocity_mode, target_velocity}, {1'b0, 32'h0000_c800})
		cmd(8'h03, 8'h00, 32'h0000_0000);
		`CHK({reply_status, velocity_mode, target_velocity, move_busy},
			{8'h64, 1'b1, 32'h0000_0000, 1'b0})
		cmd(8'h03, 8'h01, 32'h0000_0000);
		`CHK(reply_status, 8'h04)
		cmd(8'h04, 8'h00, 32'h0000_0100);
		`CHK({velocity_mode, move_busy}, {1'b0, 1'b1})
		cmd(8'h02, 8'h00, 32'h0000_c800);
		`CHK({velocity_mode, target_velocity, move_busy},
			{1'b1, 32'hffff_3800, 1'b0})
		cmd(8'h06, 8'h04, 32'h0000_0000);
		`CHK({reply_value, accumulator}, {32'h0000_c800, 32'h0})
		cmd(8'h06, 8'h05, 32'h0000_0000, 1'b1);
		`CHK(accumulator, 32'h0000_1234)
	endtask
	task automatic t_reset;
		@(posedge clock);
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		#1 `CHK({max_position_speed, target_position, accumulator},
			{32'h0000_0000, 32'h0000_0000, 32'h0000_0000})
		cmd(8'h06, 8'h04, 32'h0000_0000);
		`CHK(reply_value, 32'h0000_0000)
	endtask
	initial begin
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		t_param();
		t_moves();
		t_point();
		t_halt_read();
		t_reset();
		report_and_stop();
	end
endmodule
bind mcd_motion_command_decoder mcd_checker chk_u (
	.clock              (clock),
	.rstn               (rstn),
	.frame_valid        (frame_valid),
	.actual_position    (actual_position),
	.reply_valid        (reply_valid),
	.reply_status       (reply_status),
	.reply_code         (reply_code),
	.accumulator        (accumulator),
	.velocity_mode      (velocity_mode),
	.target_position    (target_position),
	.target_velocity    (target_velocity),
	.max_position_speed (max_position_speed),
	.move_start         (move_start),
	.move_busy          (move_busy),
	.move_distance      (move_distance)
);
`default_nettype wire
